//--- inc/iorb_pkg.sv
package iorb_pkg;

  // Register offsets: the printed offsets are not multiples of four, so each
  // is an index and the byte address on the bus is four times the index.
  localparam logic [7:0] IORB_IDX_TAPS   = 8'he4;  // Timer tap levels.
  localparam logic [7:0] IORB_IDX_LMASK  = 8'he8;  // Input line mask.
  localparam logic [7:0] IORB_IDX_TMASK  = 8'heb;  // Timer irq mask.
  localparam logic [7:0] IORB_IDX_LFACT  = 8'hed;  // Input irq factor.
  localparam logic [7:0] IORB_IDX_TFACT  = 8'hef;  // Timer irq factor.
  localparam logic [7:0] IORB_IDX_OUTCTL = 8'hf3;  // Output and tone control.
  localparam logic [7:0] IORB_IDX_PORT   = 8'hf6;  // Bidirectional port data.
  localparam logic [7:0] IORB_IDX_HLOAD  = 8'hfa;  // Heavy load control.
  localparam logic [7:0] IORB_IDX_DISP   = 8'hfb;  // Display drive control.
  localparam logic [7:0] IORB_IDX_DIR    = 8'hfc;  // Port direction control.
  localparam logic [7:0] IORB_IDX_TONE   = 8'hfd;  // Tone frequency select.
  localparam logic [7:0] IORB_IDX_LEVELS = 8'he0;  // Input line levels.
  localparam logic [7:0] IORB_IDX_ISTAT  = 8'hc0;  // Event status.
  localparam logic [7:0] IORB_IDX_IMASK  = 8'hc1;  // Event status mask.

  // Field positions.
  localparam int IORB_BIT_T32      = 0;  // Timer factor and mask, 32 Hz.
  localparam int IORB_BIT_T8       = 1;  // Timer factor and mask, 8 Hz.
  localparam int IORB_BIT_T2       = 2;  // Timer factor and mask, 2 Hz.
  localparam int IORB_BIT_FREQ_OUTPUT_ON     = 0;  // Frequency output on.
  localparam int IORB_BIT_BUZZ     = 1;  // Buzzer on.
  localparam int IORB_BIT_OUT1     = 2;  // Output port line one.
  localparam int IORB_BIT_HIGHBIT  = 3;  // Mode bit held in bit 3.
  localparam int IORB_BIT_DIR      = 0;  // Port direction bit.

  // Writable bits of each register; all others read zero.
  localparam logic [3:0] IORB_WM_TMASK  = 4'h7;
  localparam logic [3:0] IORB_WM_HIGH   = 4'h8;
  localparam logic [3:0] IORB_WM_DIR    = 4'h1;
  localparam logic [3:0] IORB_WM_TONE   = 4'hb;
  localparam logic [3:0] IORB_WM_OUTCTL = 4'hf;

  // Reset values.
  localparam logic [3:0] IORB_RST_ZERO  = 4'h0;

  // Wishbone request bundle.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] dat;
  } iorb_wb_req_t;

endpackage

//--- rtl/iorb_bank.sv
// Function
// R1 - Timer tap register read-only, four tap levels
// R2 - Input line masks read/write, reset zero
// R3 - Timer masks bits 2..0, bit3 reads zero
// R4 - Timer factor read-only, cleared at reset
// R5 - Frequency output enable read/write, reset off
// R6 - Heavy-load bit three read/write, reset normal
// R7 - Display static bit three, reset dynamic
// R8 - Port direction bit zero, reset input
// R9 - Buzzer tone select bit three, reset 4kHz
// R10 - Frequency choice bits one, zero, reset
// R11 - Constant zero bits ignore writes, read zero
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module iorb_bank
  import iorb_pkg::*;
(
  input  wire logic        clk_i,          // System clock, 50 MHz.
  input  wire logic        resetn_i,       // Asynchronous reset, active low.
  input  wire logic        wb_cyc_i,       // Wishbone cycle.
  input  wire logic        wb_stb_i,       // Wishbone strobe.
  input  wire logic        wb_we_i,        // Wishbone write enable.
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
  input  wire logic [9:0]  wb_adr_i,       // Wishbone byte address.
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
  output logic      [31:0] wb_dat_o,       // Wishbone read data.
  output logic             wb_ack_o,       // Wishbone acknowledge.
  input  wire logic [3:0]  input_line_i,   // Input port pins.
  input  wire logic [3:0]  timer_tap_i,    // Timer taps 2,4,8,16 Hz.
  input  wire logic [2:0]  timer_evt_i,    // Timer events 2,8,32 Hz.
  input  wire logic [3:0]  port_pin_i,     // Bidirectional port level.
  output logic      [3:0]  port_pin_o,     // Bidirectional port drive.
  output logic      [3:0]  port_pin_oe_o,  // Port drive enable.
  output logic      [3:0]  line_mask_o,    // Input line irq enables.
  output logic      [2:0]  timer_mask_o,   // Timer irq enables.
  output logic      [3:0]  out_ctl_o,      // Output and tone control.
  output logic             heavy_load_o,   // Heavy-load mode.
  output logic             disp_static_o,  // Static display drive.
  output logic             buzzer_tone_o,  // One selects 2 kHz tone.
  output logic      [1:0]  freq_choice_o,  // Output frequency choice.
  output logic             irq_o           // Unmasked event pending.
);

  // All checks below run on the system clock and sleep through reset, so
  // they share one default clock and one default disable condition.
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Whole state of the bank in one struct.
  typedef struct packed {
    logic [3:0]  sync1;       // Pin sync stage one, read only by sync2.
    logic [3:0]  sync2;       // Synchronised input lines.
    logic [3:0]  tap1;        // Tap sync stage one.
    logic [3:0]  tap2;        // Synchronised taps.
    logic [3:0]  pin1;        // Port pin sync stage one.
    logic [3:0]  pin2;        // Synchronised port pins.
    logic [3:0]  lines_d;     // Previous line levels for edge detect.
    logic [3:0]  lmask;       // Input line masks.
    logic [2:0]  tmask;       // Timer masks.
    logic [3:0]  lfact;       // Input line factor flags.
    logic [2:0]  tfact;       // Timer factor flags.
    logic [3:0]  outctl;      // Output control.
    logic [3:0]  port;        // Port output data.
    logic        hload;       // Heavy-load mode.
    logic        disp;        // Static drive.
    logic        dir;         // Port direction.
    logic        tone;        // Buzzer tone.
    logic [1:0]  fsel;        // Frequency choice.
    logic [3:0]  istat;       // Sticky event status.
    logic [3:0]  imask;       // Event status mask.
    logic        ack;         // Bus acknowledge.
    logic [31:0] rdat;        // Read data.
    logic        irq;         // Interrupt output.
  } iorb_state_t;

  iorb_state_t st;       // Registered state.
  iorb_state_t next_st;  // Next state.

  // Index decode shared by read and write paths.
  function automatic logic hit(input logic [7:0] idx, input logic [9:0] a);
    hit = (a[9:2] == idx);
  endfunction

  // Masked nibble write; fixed-zero bits never take a value.
  function automatic logic [3:0] wr4(input logic [3:0] old,
                                     input logic [3:0] d,
                                     input logic [3:0] wm);
    wr4 = (old & ~wm) | (d & wm);
  endfunction

  logic       req;      // New bus request this cycle.
  logic       wr;       // Write taking effect.
  logic       rd;       // Read taking effect.
  logic [3:0] wd;       // Write nibble from byte lane zero.
  logic [3:0] rnib;     // Read nibble.
  logic [3:0] line_ev;  // Input rising edges.
  logic [3:0] ev;       // Events into the status register.
  logic [3:0] tm_wr;    // Timer mask nibble after a masked write.

  // Next-state logic for the whole bank.
  always_comb begin
    next_st = st;
    req = wb_cyc_i && wb_stb_i && !st.ack;
    wr = req && wb_we_i && wb_sel_i[0];
    rd = req && !wb_we_i;
    wd = wb_dat_i[3:0];
    // Bit three of the timer mask has no storage; the write mask drops it.
    tm_wr = wr4({1'b0, st.tmask}, wd, IORB_WM_TMASK);
    // Synchronisers; first stages feed only second stages.
    next_st.sync1 = input_line_i;
    next_st.sync2 = st.sync1;
    next_st.tap1 = timer_tap_i;
    next_st.tap2 = st.tap1;
    next_st.pin1 = port_pin_i;
    next_st.pin2 = st.pin1;
    next_st.lines_d = st.sync2;
    line_ev = st.sync2 & ~st.lines_d;
    // Read mux; unmapped addresses read zero and still ack.
    rnib = 4'h0;
    if (hit(IORB_IDX_TAPS, wb_adr_i)) begin
      rnib = st.tap2;  // R1
    end else if (hit(IORB_IDX_LEVELS, wb_adr_i)) begin
      rnib = st.sync2;
    end else if (hit(IORB_IDX_LMASK, wb_adr_i)) begin
      rnib = st.lmask;
    end else if (hit(IORB_IDX_TMASK, wb_adr_i)) begin
      rnib = {1'b0, st.tmask};  // R3 R11
    end else if (hit(IORB_IDX_LFACT, wb_adr_i)) begin
      rnib = st.lfact;
    end else if (hit(IORB_IDX_TFACT, wb_adr_i)) begin
      rnib = {1'b0, st.tfact};  // R4 R11
    end else if (hit(IORB_IDX_OUTCTL, wb_adr_i)) begin
      rnib = st.outctl;
    end else if (hit(IORB_IDX_PORT, wb_adr_i)) begin
      // Output mode reads back the latch, input mode the pins.
      rnib = st.dir ? st.port : st.pin2;
    end else if (hit(IORB_IDX_HLOAD, wb_adr_i)) begin
      rnib = {st.hload, 3'h0};  // R6 R11
    end else if (hit(IORB_IDX_DISP, wb_adr_i)) begin
      rnib = {st.disp, 3'h0};  // R7 R11
    end else if (hit(IORB_IDX_DIR, wb_adr_i)) begin
      rnib = {3'h0, st.dir};  // R8 R11
    end else if (hit(IORB_IDX_TONE, wb_adr_i)) begin
      rnib = {st.tone, 1'b0, st.fsel};  // R9 R10 R11
    end else if (hit(IORB_IDX_ISTAT, wb_adr_i)) begin
      rnib = st.istat;
    end else if (hit(IORB_IDX_IMASK, wb_adr_i)) begin
      rnib = st.imask;
    end
    next_st.ack = req;
    next_st.rdat = rd ? {28'h0, rnib} : 32'h0;
    // Factor flags are sticky; reading the factor register clears them,
    // but an event in the same cycle wins over the clear.
    if (rd && hit(IORB_IDX_LFACT, wb_adr_i)) begin
      next_st.lfact = 4'h0;
    end
    if (rd && hit(IORB_IDX_TFACT, wb_adr_i)) begin
      next_st.tfact = 3'h0;  // R4
    end
    next_st.lfact = next_st.lfact | (line_ev & st.lmask);  // R2
    next_st.tfact = next_st.tfact | (timer_evt_i & st.tmask);  // R3 R4
    // Status: bit 0 input lines, bit 1 timer.
    ev = {2'b00, |(timer_evt_i & st.tmask), |(line_ev & st.lmask)};
    if (rd && hit(IORB_IDX_ISTAT, wb_adr_i)) begin
      next_st.istat = 4'h0;
    end
    next_st.istat = next_st.istat | ev;
    // Register writes.
    if (wr) begin
      if (hit(IORB_IDX_LMASK, wb_adr_i)) begin
        next_st.lmask = wd;  // R2
      end
      if (hit(IORB_IDX_TMASK, wb_adr_i)) begin
        next_st.tmask = tm_wr[2:0];  // R3
      end
      if (hit(IORB_IDX_OUTCTL, wb_adr_i)) begin
        next_st.outctl = wr4(st.outctl, wd, IORB_WM_OUTCTL);  // R5
      end
      if (hit(IORB_IDX_PORT, wb_adr_i)) begin
        next_st.port = wd;
      end
      if (hit(IORB_IDX_HLOAD, wb_adr_i)) begin
        next_st.hload = wd[IORB_BIT_HIGHBIT];  // R6 R11
      end
      if (hit(IORB_IDX_DISP, wb_adr_i)) begin
        next_st.disp = wd[IORB_BIT_HIGHBIT];  // R7 R11
      end
      if (hit(IORB_IDX_DIR, wb_adr_i)) begin
        next_st.dir = wd[IORB_BIT_DIR];  // R8 R11
      end
      if (hit(IORB_IDX_TONE, wb_adr_i)) begin
        next_st.tone = wd[IORB_BIT_HIGHBIT];  // R9 R11
        next_st.fsel = wd[1:0];  // R10
      end
      if (hit(IORB_IDX_IMASK, wb_adr_i)) begin
        next_st.imask = wd;
      end
    end
    next_st.irq = |(next_st.istat & next_st.imask);
  end

  // State register; every field resets to a constant.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;  // R2 R3 R4 R5 R6 R7 R8 R9 R10
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign wb_dat_o      = st.rdat;
  assign wb_ack_o      = st.ack;
  assign port_pin_o    = st.port;
  assign port_pin_oe_o = {4{st.dir}};
  assign line_mask_o   = st.lmask;
  assign timer_mask_o  = st.tmask;
  assign out_ctl_o     = st.outctl;
  assign heavy_load_o  = st.hload;
  assign disp_static_o = st.disp;
  assign buzzer_tone_o = st.tone;
  assign freq_choice_o = st.fsel;
  assign irq_o         = st.irq;

  // Write to the direction register one cycle before ack.
  sequence s_dir_write;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
      && hit(IORB_IDX_DIR, wb_adr_i);
  endsequence

  a_tap_readback: assert property ( // R1
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && hit(IORB_IDX_TAPS, wb_adr_i)
    |=> wb_dat_o[3:0] == $past(st.tap2))
    else $error("tap read data wrong");
  a_line_mask_wr: assert property ( // R2
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
      && hit(IORB_IDX_LMASK, wb_adr_i)
    |=> line_mask_o == $past(wb_dat_i[3:0]))
    else $error("line mask write lost");
  a_tmask_top_zero: assert property ( // R3
    wb_ack_o && $past(hit(IORB_IDX_TMASK, wb_adr_i) && !wb_we_i)
    |-> wb_dat_o[3] == 1'b0)
    else $error("timer mask bit3 not zero");
  a_tfact_set: assert property ( // R4
    timer_evt_i[IORB_BIT_T32] && timer_mask_o[IORB_BIT_T32]
    |=> st.tfact[IORB_BIT_T32])
    else $error("32 Hz factor not set");
  a_freq_output_on_write: assert property ( // R5
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
      && hit(IORB_IDX_OUTCTL, wb_adr_i)
    |=> out_ctl_o[IORB_BIT_FREQ_OUTPUT_ON] == $past(wb_dat_i[IORB_BIT_FREQ_OUTPUT_ON]))
    else $error("frequency output enable lost");
  a_hload_read: assert property ( // R6
    wb_ack_o && $past(hit(IORB_IDX_HLOAD, wb_adr_i) && !wb_we_i)
    |-> wb_dat_o[3:0] == {$past(heavy_load_o), 3'h0})
    else $error("heavy load read wrong");
  a_disp_read: assert property ( // R7
    wb_ack_o && $past(hit(IORB_IDX_DISP, wb_adr_i) && !wb_we_i)
    |-> wb_dat_o[2:0] == 3'h0)
    else $error("display low bits not zero");
  a_dir_drive: assert property ( // R8
    s_dir_write |=> port_pin_oe_o == {4{$past(wb_dat_i[0])}})
    else $error("direction not applied");
  a_tone_write: assert property ( // R9
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
      && hit(IORB_IDX_TONE, wb_adr_i)
    |=> buzzer_tone_o == $past(wb_dat_i[3])
      && freq_choice_o == $past(wb_dat_i[1:0]))  // R10
    else $error("tone select lost");

  // The checks below describe the bus answer and the register fields in
  // terms of the request shapes that follow. A request counts only in the
  // cycle before ack, which is the one cycle in which the bank takes it;
  // the cycle with ack high is ignored so a held request is never doubled.

  // Any request that the bank takes.
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  // A read of one index, in the cycle the bank takes it.
  sequence s_rd_of(logic [7:0] idx);
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit(idx, wb_adr_i);
  endsequence

  // A write of one index with the low byte lane selected.
  sequence s_wr_of(logic [7:0] idx);
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
      && hit(idx, wb_adr_i);
  endsequence

  // The answer: ack stands for exactly one cycle and then drops.
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  // Every taken request is answered in the next cycle, for one cycle only;
  // a longer ack would let a held request be taken twice.
  a_ack_one_cycle: assert property (
    s_taken |=> s_ack_pulse)
    else $error("ack not a single pulse");

  // Read data is zero outside a read answer, so a stale nibble never
  // shows on the bus while no read is being answered.
  a_dat_idle_zero: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero when idle");

  // Only the low nibble of an answer ever carries data; the rest of the
  // word is constant zero and cannot be changed by software.
  a_dat_upper_zero: assert property ( // R11
    wb_ack_o |-> wb_dat_o[31:4] == 28'h0)
    else $error("upper read bits not zero");

  // The line mask reads back what it holds when the read is taken.
  // Software relies on this for read-modify-write of single enables.
  a_lmask_read: assert property ( // R2
    s_rd_of(IORB_IDX_LMASK) |=> wb_dat_o[3:0] == $past(line_mask_o))
    else $error("line mask read wrong");

  // A timer mask write keeps the three enables; bit three has no storage
  // and so the written value there is simply lost.
  a_tmask_write: assert property ( // R3
    s_wr_of(IORB_IDX_TMASK) |=> timer_mask_o == $past(wb_dat_i[2:0]))
    else $error("timer mask write lost");

  // A timer factor flag only sets while its enable was open, so a masked
  // tick can never leave a flag behind for software to find later.
  a_timer_flag_mask: assert property ( // R3
    (st.tfact & ~$past(st.tfact) & ~$past(timer_mask_o)) == 3'h0)
    else $error("masked timer event set a flag");

  // The timer factor read returns the flags as they stood at the read.
  // Bit three has no flag and always reads zero.
  a_tfact_read: assert property ( // R4
    s_rd_of(IORB_IDX_TFACT) |=> wb_dat_o[3:0] == {1'b0, $past(st.tfact)})
    else $error("timer factor read wrong");

  // Reading the timer factor with no new tick leaves every flag clear;
  // a tick in the same cycle would win and is left out here.
  a_tfact_clear: assert property ( // R4
    s_rd_of(IORB_IDX_TFACT) ##0 (timer_evt_i == 3'h0)
    |=> st.tfact == 3'h0)
    else $error("timer factor not cleared");

  // All four output control bits take the written nibble, the frequency
  // output enable among them.
  a_outctl_write: assert property ( // R5
    s_wr_of(IORB_IDX_OUTCTL) |=> out_ctl_o == $past(wb_dat_i[3:0]))
    else $error("output control write lost");

  // The heavy-load mode takes bit three of the written nibble; the three
  // lower bits of the write are ignored.
  a_hload_write: assert property ( // R6
    s_wr_of(IORB_IDX_HLOAD) |=> heavy_load_o == $past(wb_dat_i[3]))
    else $error("heavy load write lost");

  // The display drive mode takes bit three of the written nibble.
  // The lower bits have no storage behind them.
  a_disp_write: assert property ( // R7
    s_wr_of(IORB_IDX_DISP) |=> disp_static_o == $past(wb_dat_i[3]))
    else $error("display mode write lost");

  // The direction register shows only its lowest bit; the upper three
  // read zero whatever was written there.
  a_dir_read: assert property ( // R8
    s_rd_of(IORB_IDX_DIR) |=> wb_dat_o[3:1] == 3'h0)
    else $error("direction upper bits not zero");

  // The gap between the buzzer bit and the frequency choice reads zero.
  // A write of ones there must not show up on the next read.
  a_tone_gap_zero: assert property ( // R9
    s_rd_of(IORB_IDX_TONE) |=> wb_dat_o[2] == 1'b0)
    else $error("tone bit two not zero");

  // A line factor flag only sets while its line was enabled, so a masked
  // edge can never leave a flag behind.
  a_line_flag_mask: assert property ( // R2
    (st.lfact & ~$past(st.lfact) & ~$past(line_mask_o)) == 4'h0)
    else $error("masked line event set a flag");

  // The interrupt level is the OR of all the unmasked status bits;
  // it is registered, so it settles in the same cycle as the status.
  a_irq_level: assert property ( // R3
    irq_o == |(st.istat & st.imask))
    else $error("interrupt level wrong");

endmodule // iorb_bank

//--- sim/tb.sv
`timescale 1ns/1ps
module tb
  import iorb_pkg::*;
;

  logic         clk_i         = 1'b0;   // System clock, 50 MHz.
  logic         resetn_i      = 1'b0;   // Reset, held low at start.
  iorb_wb_req_t req           = '0;     // Wishbone request bundle.
  logic [3:0]   input_line_i  = 4'h0;   // Input port pins.
  logic [3:0]   timer_tap_i   = 4'h0;   // Timer tap levels.
  logic [2:0]   timer_evt_i   = 3'h0;   // Timer event pulses.
  logic [3:0]   port_pin_i    = 4'h0;   // Bidirectional port level.
  logic [31:0]  wb_dat_o;               // Read data.
  logic         wb_ack_o;               // Acknowledge.
  logic [3:0]   port_pin_o;             // Port drive.
  logic [3:0]   port_pin_oe_o;          // Port drive enable.
  logic [3:0]   line_mask_o;            // Line irq enables.
  logic [2:0]   timer_mask_o;           // Timer irq enables.
  logic [3:0]   out_ctl_o;              // Output control.
  logic         heavy_load_o;           // Heavy-load mode.
  logic         disp_static_o;          // Static display drive.
  logic         buzzer_tone_o;          // Buzzer tone select.
  logic [1:0]   freq_choice_o;          // Frequency choice.
  logic         irq_o;                  // Interrupt level.
  int           n_mismatch    = 0;      // Mismatches seen.
  int           total_checks  = 0;      // Comparisons made.
  // Writable registers and the bits that survive an all-ones write.
  logic [7:0]   widx [7] = '{IORB_IDX_LMASK, IORB_IDX_TMASK, IORB_IDX_OUTCTL,
    IORB_IDX_HLOAD, IORB_IDX_DISP, IORB_IDX_DIR, IORB_IDX_TONE};
  logic [3:0]   wwm  [7] = '{4'hf, 4'h7, 4'hf, 4'h8, 4'h8, 4'h1, 4'hb};

  // The clock toggles every half period.
  always #10 clk_i = ~clk_i;

  iorb_bank i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(req.cyc),
    .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
    .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .input_line_i(input_line_i),
    .timer_tap_i(timer_tap_i), .timer_evt_i(timer_evt_i),
    .port_pin_i(port_pin_i), .port_pin_o(port_pin_o),
    .port_pin_oe_o(port_pin_oe_o), .line_mask_o(line_mask_o),
    .timer_mask_o(timer_mask_o), .out_ctl_o(out_ctl_o),
    .heavy_load_o(heavy_load_o), .disp_static_o(disp_static_o),
    .buzzer_tone_o(buzzer_tone_o), .freq_choice_o(freq_choice_o),
    .irq_o(irq_o));

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One classic Wishbone cycle; the request stands until ack is sampled.
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [3:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    @(posedge clk_i);
    req <= '{cyc:1'b1, stb:1'b1, we:w, sel:s, adr:{idx, 2'b00},
             dat:{28'h0, d}};
    // No cycle count is assumed; only the watchdog ends a missing answer.
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [3:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, 4'hf, q);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 4'h0, 4'hf, q);
    chk(q, exp);
  endtask

  // A single-cycle timer event, as the timer circuit would give it.
  task automatic pulse(input logic [2:0] e);
    @(posedge clk_i);
    timer_evt_i <= e;
    @(posedge clk_i);
    timer_evt_i <= 3'h0;
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    logic [31:0] q;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    // Reset values, then all-ones and all-zeros writes per register.
    for (int i = 0; i < 7; i++) rdc(widx[i], 32'h0);
    rdc(IORB_IDX_TFACT, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(widx[i], 4'hf);
      rdc(widx[i], {28'h0, wwm[i]});
    end
    chk({16'h0, line_mask_o, timer_mask_o, out_ctl_o, heavy_load_o,
         disp_static_o, buzzer_tone_o, freq_choice_o}, 32'hffff);
    for (int i = 0; i < 7; i++) wr(widx[i], 4'h0);
    chk({16'h0, line_mask_o, timer_mask_o, out_ctl_o, heavy_load_o,
         disp_static_o, buzzer_tone_o, freq_choice_o}, 32'h0);
    // A write without the low byte select must leave the mask alone.
    bus(1'b1, IORB_IDX_LMASK, 4'h5, 4'he, q);
    rdc(IORB_IDX_LMASK, 32'h0);
    // Every frequency choice code, then the slower buzzer tone.
    for (int i = 0; i < 4; i++) begin
      wr(IORB_IDX_TONE, 4'(i));
      chk({30'h0, freq_choice_o}, 32'(i));
    end
    wr(IORB_IDX_TONE, 4'h8);
    chk({31'h0, buzzer_tone_o}, 32'h1);
    // Tap levels pass through the synchroniser; writes have no effect.
    timer_tap_i <= 4'h9;
    repeat (4) @(posedge clk_i);
    wr(IORB_IDX_TAPS, 4'h6);
    rdc(IORB_IDX_TAPS, 32'h9);
    rdc(8'h10, 32'h0);
    // Port in output mode drives the latch, in input mode reads pins.
    wr(IORB_IDX_DIR, 4'h1);
    wr(IORB_IDX_PORT, 4'h5);
    chk({24'h0, port_pin_oe_o, port_pin_o}, 32'hf5);
    rdc(IORB_IDX_PORT, 32'h5);
    wr(IORB_IDX_DIR, 4'h0);
    port_pin_i <= 4'ha;
    repeat (4) @(posedge clk_i);
    chk({28'h0, port_pin_oe_o}, 32'h0);
    rdc(IORB_IDX_PORT, 32'ha);
    // Two lines rise, only line 0 enabled, so only its flag is set.
    wr(IORB_IDX_LMASK, 4'h1);
    input_line_i <= 4'h3;
    repeat (6) @(posedge clk_i);
    rdc(IORB_IDX_LEVELS, 32'h3);
    rdc(IORB_IDX_LFACT, 32'h1);
    rdc(IORB_IDX_LFACT, 32'h0);
    rdc(IORB_IDX_ISTAT, 32'h1);
    // Unmasked timer event raises the interrupt until status is read.
    wr(IORB_IDX_TMASK, 4'h1);
    wr(IORB_IDX_IMASK, 4'h2);
    pulse(3'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rdc(IORB_IDX_TFACT, 32'h1);
    rdc(IORB_IDX_TFACT, 32'h0);
    rdc(IORB_IDX_ISTAT, 32'h2);
    chk({31'h0, irq_o}, 32'h0);
    // With the status mask closed the event is recorded but silent.
    wr(IORB_IDX_IMASK, 4'h0);
    pulse(3'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rdc(IORB_IDX_ISTAT, 32'h2);
    // A second reset in mid-run returns the mode bit to normal.
    wr(IORB_IDX_HLOAD, 4'h8);
    chk({31'h0, heavy_load_o}, 32'h1);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk({31'h0, heavy_load_o}, 32'h0);
    rdc(IORB_IDX_HLOAD, 32'h0);
    report_and_stop();
  end

endmodule // tb
